// File: ovl_regs.svh
`ifndef OVL_REGS_SVH
`define OVL_REGS_SVH

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define OVL_CMD_OV_WARN        8'h42
`define OVL_CMD_UV_WARN        8'h43
`define OVL_CMD_UV_FAULT       8'h44
`define OVL_CMD_UV_ACTION      8'h45

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define OVL_EXP_HI             15
`define OVL_EXP_LO             11
`define OVL_MANT_HI            10
`define OVL_MANT_LO            0
`define OVL_MODE_EXP_HI        2
`define OVL_MODE_EXP_LO        0
`define OVL_ACT_RESP_HI        7
`define OVL_ACT_RESP_LO        6
`define OVL_ACT_RETRY_HI       5
`define OVL_ACT_RETRY_LO       3
`define OVL_ACT_DELAY_HI       2
`define OVL_ACT_DELAY_LO       0

// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define OVL_MANT_RESET         11'h000
`define OVL_ACTION_RESET       8'h00
`define OVL_RESP_NONE          2'h0
`define OVL_RESP_DELAYED       2'h1
`define OVL_RESP_NOW           2'h2
`define OVL_RETRY_FOREVER      3'h7

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define OVL_CLK_HZ             250000000
`define OVL_TICK_MS            1
`define OVL_DELAY1_BASE_MS     12'h00a
`define OVL_D2_0_MS            12'd252
`define OVL_D2_1_MS            12'd558
`define OVL_D2_2_MS            12'd924
`define OVL_D2_3_MS            12'd1260
`define OVL_D2_4_MS            12'd1596
`define OVL_D2_5_MS            12'd1932
`define OVL_D2_6_MS            12'd2268
`define OVL_D2_7_MS            12'd2604

`endif

// File: ovl_pkg.sv
package ovl_pkg;

  typedef enum logic [2:0] {
    OVL_IDLE       = 3'h0,
    OVL_DELAY      = 3'h1,
    OVL_RETRY_WAIT = 3'h3,
    OVL_LATCHED    = 3'h2,
    OVL_WAIT_CLEAR = 3'h6
  } ovl_state_t;

  typedef struct packed {
    logic [10:0] ov_warn_mant;
    logic [10:0] uv_warn_mant;
    logic [10:0] uv_fault_mant;
    logic [7:0]  action;
    logic [15:0] rdata;
    logic        scl_prev;
    logic        ov_warn_flag;
    logic        uv_warn_flag;
    logic        uv_fault_flag;
    ovl_state_t  state;
    logic [11:0] timer_ms;
    logic [17:0] tick_cnt;
    logic [2:0]  retry_left;
    logic        retrying;
    logic        vout_en;
  } ovl_regs_t;

endpackage

// File: ovl_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ovl_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ovl_sync_t;

  ovl_sync_t sync_reg;
  ovl_sync_t sync_next;

  always_comb begin
    sync_next.meta   = async_in;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg.stable;

endmodule

`default_nettype wire

// File: ovl_limit_regs.sv
// Notes on behaviour
// [RULE_01] threshold reads give bits 15:11 as exponent from mode bits 2:0
// [RULE_02] exponent is signed two's complement when decoding the threshold
// [RULE_03] threshold holds writable 11-bit mantissa in bits 10:8 and 7:0
// [RULE_04] raise overvoltage warning when output crosses the 0x42 threshold
// [RULE_05] undervoltage warning when output falls below the 0x43 threshold
// [RULE_06] undervoltage fault when output falls below the 0x44 threshold
// [RULE_07] action bits 7:6 select fault response; 00 does nothing
// [RULE_08] code 01 waits first delay, acts only if fault persists
// [RULE_09] after shutdown, restart up to retry count in bits 5:3
// [RULE_10] first delay 10 ms doubling to 1280 ms; second 252 to 2604 ms
// [RULE_11] fault left after retries keeps output off until reset
// [RULE_12] code 10 shuts down at once, then retries per retry count
// [RULE_13] compare decoded values, same exponent; flags sticky until cleared
`timescale 1ns/1ps
`default_nettype none
`include "ovl_regs.svh"

module ovl_limit_regs #(
  parameter int TICK_CYCLES = `OVL_CLK_HZ / 1000 * `OVL_TICK_MS
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // management link (asynchronous pins)
  input  wire logic        link_clk_in,
  input  wire logic        link_wr_in,
  input  wire logic [7:0]  link_cmd_in,
  input  wire logic [15:0] link_wdata_in,
  output logic      [15:0] link_rdata_out,
  // core side
  input  wire logic [7:0]  output_format_mode_in,
  input  wire logic [10:0] vout_meas_in,
  input  wire logic        clear_flags_in,
  output logic             ov_warn_out,
  output logic             uv_warn_out,
  output logic             uv_fault_out,
  output logic             vout_enable_out
);

  // -------------------------------------------------------------
  // link sampling
  // -------------------------------------------------------------
  logic        scl_s;
  logic        wr_s;
  logic [7:0]  cmd_s;
  logic [15:0] wdata_s;

  ovl_sync #(.WIDTH(26)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   ({link_clk_in, link_wr_in, link_cmd_in, link_wdata_in}),
    .sync_out   ({scl_s, wr_s, cmd_s, wdata_s})
  );

  // -------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------
  // sign extension keeps negative 3-bit codes negative
  function automatic logic signed [4:0] exp_of(input logic [7:0] mode);
    logic [2:0] code;
    code   = mode[`OVL_MODE_EXP_HI:`OVL_MODE_EXP_LO];
    exp_of = {{2{code[2]}}, code}; // [RULE_01]
  endfunction

  function automatic logic [31:0] lin_decode(input logic [10:0] mant,
                                             input logic signed [4:0] e);
    logic [31:0] base;
    base = {21'h00000, mant};
    if (e < 0) begin
      lin_decode = base >> (-e); // [RULE_02]
    end else begin
      lin_decode = base << e;    // [RULE_02]
    end
  endfunction

  function automatic logic [11:0] delay2_ms(input logic [2:0] code);
    logic [11:0] ms;
    ms = `OVL_D2_0_MS;
    unique case (code)
      3'h0: ms = `OVL_D2_0_MS;
      3'h1: ms = `OVL_D2_1_MS;
      3'h2: ms = `OVL_D2_2_MS;
      3'h3: ms = `OVL_D2_3_MS;
      3'h4: ms = `OVL_D2_4_MS;
      3'h5: ms = `OVL_D2_5_MS;
      3'h6: ms = `OVL_D2_6_MS;
      3'h7: ms = `OVL_D2_7_MS;
    endcase
    delay2_ms = ms; // [RULE_10]
  endfunction

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  ovl_pkg::ovl_regs_t r_reg;
  ovl_pkg::ovl_regs_t r_next;

  logic signed [4:0] exp_n;
  logic [31:0]       meas_v;
  logic              uv_fault_now;
  logic              scl_rise;
  logic [1:0]        resp;
  logic [2:0]        retries;
  logic [2:0]        dcode;
  logic              tick;
  logic [10:0]       wmant;

  always_comb begin
    exp_n        = exp_of(output_format_mode_in);
    meas_v       = lin_decode(vout_meas_in, exp_n);
    uv_fault_now = meas_v < lin_decode(r_reg.uv_fault_mant,
                                       exp_n);           // [RULE_06]
    wmant        = wdata_s[`OVL_MANT_HI:`OVL_MANT_LO];   // [RULE_03]
    scl_rise     = scl_s && !r_reg.scl_prev;
    resp    = r_reg.action[`OVL_ACT_RESP_HI:`OVL_ACT_RESP_LO];     // [RULE_07]
    retries = r_reg.action[`OVL_ACT_RETRY_HI:`OVL_ACT_RETRY_LO];
    dcode   = r_reg.action[`OVL_ACT_DELAY_HI:`OVL_ACT_DELAY_LO];
    tick    = (r_reg.tick_cnt == 18'(TICK_CYCLES - 1));
  end

  always_comb begin
    r_next          = r_reg;
    r_next.scl_prev = scl_s;

    // -------------------------------------------------------------
    // register access on link clock rising edge
    // -------------------------------------------------------------
    if (scl_rise) begin
      if (wr_s) begin
        unique case (cmd_s)
          `OVL_CMD_OV_WARN:
            r_next.ov_warn_mant = wmant;  // [RULE_03]
          `OVL_CMD_UV_WARN:
            r_next.uv_warn_mant = wmant;  // [RULE_03]
          `OVL_CMD_UV_FAULT:
            r_next.uv_fault_mant = wmant; // [RULE_03]
          `OVL_CMD_UV_ACTION:
            r_next.action = wdata_s[7:0];
          default: ;
        endcase
      end
      // exponent field is read-only: writes above never touch it
      unique case (cmd_s)
        `OVL_CMD_OV_WARN:
          r_next.rdata = {exp_n, r_reg.ov_warn_mant};  // [RULE_01]
        `OVL_CMD_UV_WARN:
          r_next.rdata = {exp_n, r_reg.uv_warn_mant};  // [RULE_01]
        `OVL_CMD_UV_FAULT:
          r_next.rdata = {exp_n, r_reg.uv_fault_mant}; // [RULE_01]
        `OVL_CMD_UV_ACTION:
          r_next.rdata = {8'h00, r_reg.action};
        default:
          r_next.rdata = 16'h0000;
      endcase
    end

    // -------------------------------------------------------------
    // sticky flags, set wins over clear
    // -------------------------------------------------------------
    if (clear_flags_in) begin
      r_next.ov_warn_flag  = 1'b0;
      r_next.uv_warn_flag  = 1'b0;
      r_next.uv_fault_flag = 1'b0;
    end
    if (meas_v > lin_decode(r_reg.ov_warn_mant, exp_n)) begin
      r_next.ov_warn_flag = 1'b1;  // [RULE_04] [RULE_13]
    end
    if (meas_v < lin_decode(r_reg.uv_warn_mant, exp_n)) begin
      r_next.uv_warn_flag = 1'b1;  // [RULE_05] [RULE_13]
    end
    if (uv_fault_now) begin
      r_next.uv_fault_flag = 1'b1; // [RULE_06] [RULE_13]
    end

    // -------------------------------------------------------------
    // millisecond tick and fault response
    // -------------------------------------------------------------
    r_next.tick_cnt = tick ? 18'h00000 : r_reg.tick_cnt + 18'h00001;
    if (tick && r_reg.timer_ms != 12'h000) begin
      r_next.timer_ms = r_reg.timer_ms - 12'h001;
    end

    unique case (r_reg.state)
      ovl_pkg::OVL_IDLE: begin
        r_next.vout_en = 1'b1;
        if (!uv_fault_now) begin
          r_next.retrying = 1'b0;
        end else if (resp == `OVL_RESP_DELAYED) begin
          r_next.timer_ms = `OVL_DELAY1_BASE_MS << dcode; // [RULE_10]
          r_next.state    = ovl_pkg::OVL_DELAY;
        end else if (resp == `OVL_RESP_NOW) begin
          r_next.vout_en  = 1'b0;                         // [RULE_12]
          r_next.timer_ms = delay2_ms(dcode);
          if (!r_reg.retrying) begin
            r_next.retry_left = retries;                  // [RULE_09]
          end
          r_next.state = (r_reg.retrying && r_reg.retry_left == 3'h0) ||
                         (!r_reg.retrying && retries == 3'h0) ?
                         ovl_pkg::OVL_LATCHED : ovl_pkg::OVL_RETRY_WAIT;
        end else if (resp != `OVL_RESP_NONE) begin
          r_next.vout_en = 1'b0;
          r_next.state   = ovl_pkg::OVL_WAIT_CLEAR;
        end
      end
      ovl_pkg::OVL_DELAY: begin
        if (!uv_fault_now) begin
          r_next.state = ovl_pkg::OVL_IDLE;               // [RULE_08]
        end else if (r_reg.timer_ms == 12'h000) begin
          r_next.vout_en  = 1'b0;                         // [RULE_08]
          r_next.timer_ms = delay2_ms(dcode);
          if (!r_reg.retrying) begin
            r_next.retry_left = retries;                  // [RULE_09]
          end
          r_next.state = (r_reg.retrying && r_reg.retry_left == 3'h0) ||
                         (!r_reg.retrying && retries == 3'h0) ?
                         ovl_pkg::OVL_LATCHED : ovl_pkg::OVL_RETRY_WAIT;
        end
      end
      ovl_pkg::OVL_RETRY_WAIT: begin
        r_next.vout_en = 1'b0;
        if (r_reg.timer_ms == 12'h000) begin
          // code 7 retries without end, so never count down
          if (r_reg.retry_left != `OVL_RETRY_FOREVER) begin
            r_next.retry_left = r_reg.retry_left - 3'h1;  // [RULE_09]
          end
          r_next.retrying = 1'b1;
          r_next.vout_en  = 1'b1;
          r_next.state    = ovl_pkg::OVL_IDLE;
        end
      end
      ovl_pkg::OVL_LATCHED: begin
        r_next.vout_en = 1'b0;                            // [RULE_11]
      end
      ovl_pkg::OVL_WAIT_CLEAR: begin
        r_next.vout_en = !uv_fault_now;
        if (!uv_fault_now) begin
          r_next.state = ovl_pkg::OVL_IDLE;
        end
      end
      default: begin
        r_next.vout_en = 1'b0;
        r_next.state   = ovl_pkg::OVL_LATCHED;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_reg               <= '0;
      r_reg.ov_warn_mant  <= `OVL_MANT_RESET;
      r_reg.uv_warn_mant  <= `OVL_MANT_RESET;
      r_reg.uv_fault_mant <= `OVL_MANT_RESET;
      r_reg.action        <= `OVL_ACTION_RESET;
      r_reg.state         <= ovl_pkg::OVL_IDLE;
      r_reg.vout_en       <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link_rdata_out  = r_reg.rdata;
  assign ov_warn_out     = r_reg.ov_warn_flag;
  assign uv_warn_out     = r_reg.uv_warn_flag;
  assign uv_fault_out    = r_reg.uv_fault_flag;
  assign vout_enable_out = r_reg.vout_en;

endmodule

`default_nettype wire

// File: ovl_limit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ovl_limit_monitor (
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  // observed pins
  input wire logic        link_clk_in,
  input wire logic [15:0] link_rdata_out,
  input wire logic [10:0] vout_meas_in,
  input wire logic        clear_flags_in,
  input wire logic        ov_warn_out,
  input wire logic        uv_warn_out,
  input wire logic        uv_fault_out,
  input wire logic        vout_enable_out
);
  default clocking mon_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  ov_hold_a:
    assert property (ov_warn_out && !clear_flags_in |=> ov_warn_out)
    else $error("ov warning dropped");
  uvf_hold_a:
    assert property (uv_fault_out && !clear_flags_in |=> uv_fault_out)
    else $error("uv fault dropped");
  ov_cause_a:
    assert property ($rose(ov_warn_out) |-> $past(vout_meas_in) != 11'h000)
    else $error("ov warning without cause");
  uvw_cause_a:
    assert property ($rose(uv_warn_out) |-> $past(vout_meas_in) != 11'h7ff)
    else $error("uv warning without cause");
  uvf_cause_a:
    assert property ($rose(uv_fault_out) |-> $past(vout_meas_in) != 11'h7ff)
    else $error("uv fault without cause");
  uv_clear_a:
    assert property (clear_flags_in && vout_meas_in == 11'h7ff
      |=> !uv_warn_out && !uv_fault_out) else $error("uv flags stuck");
  rdata_quiet_a:
    assert property (!link_clk_in [*8] |=> $stable(link_rdata_out))
    else $error("read data moved with link idle");
  off_cause_a:
    assert property ($fell(vout_enable_out) |-> uv_fault_out)
    else $error("output disabled without fault");
endmodule
`default_nettype wire

// File: ovl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ovl_host_model (
  // clock
  input  wire logic        sys_clk_in,
  // link pins
  output logic             link_clk_out,
  output logic             link_wr_out,
  output logic [7:0]       link_cmd_out,
  output logic [15:0]      link_wdata_out,
  input  wire logic [15:0] link_rdata_in
);
  // link clock only runs inside an access
  initial link_clk_out = 1'b0;
  initial link_wr_out = 1'b0;
  initial link_cmd_out = 8'h00;
  initial link_wdata_out = 16'h0000;
  task automatic access(input logic wr, input logic [7:0] cmd,
                        input logic [15:0] wd, output logic [15:0] rd);
    @(posedge sys_clk_in) #1;
    link_wr_out = wr;
    link_cmd_out = cmd;
    link_wdata_out = wd;
    repeat (2) @(posedge sys_clk_in);
    #1 link_clk_out = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    #1 link_clk_out = 1'b0;
    // one more edge keeps the link period at 32 ns back to back
    @(posedge sys_clk_in);
    rd = link_rdata_in;
    // released lines flip so a stale value never looks valid
    #1 link_cmd_out = ~cmd;
    link_wdata_out = ~wd;
    link_wr_out = ~wr;
  endtask
endmodule
`default_nettype wire

// File: ovl_limit_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
bind ovl_limit_regs ovl_limit_monitor mon_u (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
  .link_rdata_out(link_rdata_out), .vout_meas_in(vout_meas_in),
  .clear_flags_in(clear_flags_in), .ov_warn_out(ov_warn_out),
  .uv_warn_out(uv_warn_out), .uv_fault_out(uv_fault_out),
  .vout_enable_out(vout_enable_out));
module ovl_limit_regs_tb;
  logic        clk = 1'b0, rst = 1'b1, clr = 1'b0;
  logic        lclk, lwr, ov, uvw, uvf, en;
  logic [7:0]  lcmd, mode = 8'h00;
  logic [15:0] lwd, lrd, junk;
  logic [10:0] meas = 11'h000;
  int          error_cnt = 0, checks_done = 0;
  always #2 clk = ~clk;
  ovl_limit_regs #(.TICK_CYCLES(4)) dut_u (
    .sys_clk_in(clk), .rst_in(rst), .link_clk_in(lclk), .link_wr_in(lwr),
    .link_cmd_in(lcmd), .link_wdata_in(lwd), .link_rdata_out(lrd),
    .output_format_mode_in(mode), .vout_meas_in(meas),
    .clear_flags_in(clr), .ov_warn_out(ov), .uv_warn_out(uvw),
    .uv_fault_out(uvf), .vout_enable_out(en));
  ovl_host_model host_u (
    .sys_clk_in(clk), .link_clk_out(lclk), .link_wr_out(lwr),
    .link_cmd_out(lcmd), .link_wdata_out(lwd), .link_rdata_in(lrd));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // bounded wait; running out ends the run
  task automatic wait_en(input logic v, input int lim);
    for (int n = 0; n < lim && en !== v; n++) cyc(1);
    chk("enable wait", {15'h0, v}, {15'h0, en});
    if (en !== v) results();
  endtask
  task automatic hold_en(input logic v, input int n);
    logic bad = 1'b0;
    repeat (n) begin
      cyc(1);
      if (en !== v) bad = 1'b1;
    end
    chk("enable hold", 16'h0, {15'h0, bad});
  endtask
  task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
    host_u.access(1'b0, cmd, 16'h0000, junk);
    chk($sformatf("register %h", cmd), exp, junk);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] wd);
    host_u.access(1'b1, cmd, wd, junk);
  endtask
  task automatic clear_flags();
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(2);
  endtask
  task automatic chk_flags(input logic [2:0] exp);
    cyc(3);
    chk("flags", {13'h0, exp}, {13'h0, ov, uvw, uvf});
  endtask
  // good level, flags cleared, response armed, then the fault
  task automatic arm(input logic [7:0] act);
    meas = 11'h350;
    clear_flags();
    wr(8'h45, {8'h00, act});
    meas = 11'h100;
  endtask
  task automatic t_format();
    logic [2:0] x;
    logic [7:0] r;
    for (int e = 0; e < 8; e++) begin
      x = 3'(e);
      r = 8'h42 + 8'(e % 3);
      mode = {5'h1f, x};
      wr(r, {5'h0a, x, 8'h5a});
      rd_chk(r, {{2{x[2]}}, x, x, 8'h5a});
    end
    rd_chk(8'h45, 16'h0000);
    $display("test format done");
  endtask
  task automatic t_flags();
    logic [10:0] mv [6] = '{11'h400, 11'h401, 11'h2ff, 11'h200, 11'h1ff,
                            11'h350};
    logic [2:0]  fx [6] = '{3'h0, 3'h4, 3'h6, 3'h6, 3'h7, 3'h7};
    mode = 8'h00;
    wr(8'h42, 16'h0400);
    wr(8'h43, 16'h0300);
    wr(8'h44, 16'h0200);
    meas = 11'h350;
    clear_flags();
    for (int i = 0; i < 6; i++) begin
      meas = mv[i];
      chk_flags(fx[i]);
    end
    meas = 11'h7ff;
    clear_flags();
    chk_flags(3'h4);
    $display("test flags done");
  endtask
  task automatic t_response();
    arm(8'h00);
    hold_en(1'b1, 40);
    arm(8'hc0);
    wait_en(1'b0, 8);
    meas = 11'h350;
    wait_en(1'b1, 8);
    arm(8'h80);
    wait_en(1'b0, 4);
    meas = 11'h350;
    hold_en(1'b0, 200);
    rst = 1'b1;
    cyc(5);
    rst = 1'b0;
    wait_en(1'b1, 1);
    $display("test response done");
  endtask
  // one tick is 4 cycles: delay one code 1 is 80, delay two is 2232
  task automatic t_retry();
    wr(8'h44, 16'h0200);
    arm(8'h49);
    cyc(40);
    arm(8'h49);
    hold_en(1'b1, 68);
    wait_en(1'b0, 24);
    hold_en(1'b0, 2200);
    wait_en(1'b1, 70);
    wait_en(1'b0, 120);
    hold_en(1'b0, 2400);
    $display("test retry done");
  endtask
  // retry code 7 never runs out: more pulses than any finite count
  task automatic t_forever();
    rst = 1'b1;
    cyc(5);
    rst = 1'b0;
    wr(8'h44, 16'h0200);
    arm(8'hb8);
    wait_en(1'b0, 4);
    for (int i = 0; i < 9; i++) begin
      wait_en(1'b1, 1100);
      wait_en(1'b0, 2);
    end
    $display("test forever done");
  endtask
  initial begin
    cyc(5);
    rst = 1'b0;
    t_format();
    t_flags();
    t_response();
    t_retry();
    t_forever();
    results();
  end
endmodule
`default_nettype wire
